// ### design/fsp_pkg.sv
package fsp_pkg;
  // Status word low bit positions
  localparam int SL_BUSY = 0;
  localparam int SL_WLATCH = 1;
  localparam int SL_PROT_LO = 2;
  localparam int SL_LOCK_LO = 7;
  // Status word high bit positions
  localparam int SH_LOCK_HI = 0;
  localparam int SH_QUAD = 1;
  localparam int SH_SEC_LO = 2;
  localparam int SH_SEC_HI = 3;
  localparam int SH_DUMMY = 4;
  localparam int SH_CMP = 6;
  localparam int SH_SUSP = 7;
  // Power-up values of the stored bits
  localparam logic [4:0] PROT_RST = 5'h00;
  localparam logic CMP_RST = 1'b0;
  localparam logic [1:0] LOCK_RST = 2'h0;
  // Array and unit geometry
  localparam int ADDR_W = 24;
  localparam logic [23:0] ARRAY_TOP = 24'h0fffff;
  localparam logic [23:0] BLK64 = 24'h010000;
  localparam logic [23:0] SEC4K = 24'h001000;
  // Commands to the protection block
  typedef enum logic [2:0] {
    FSP_OP_NONE = 3'h0,
    FSP_OP_WREN = 3'h1,
    FSP_OP_WRDI = 3'h2,
    FSP_OP_STATUS_WRITE_CMD = 3'h3,
    FSP_OP_PAGE = 3'h4,
    FSP_OP_SECT = 3'h5,
    FSP_OP_B32 = 3'h6,
    FSP_OP_B64 = 3'h7
  } fsp_op_e;
  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_BUSY = 2'b01
  } fsp_state_e;
endpackage

// ### design/fsp_decode.sv
`timescale 1ns/1ps
// Combinational map of protect field and complement bit to a protected range
module fsp_decode (
  input wire logic [4:0] prot,
  input wire logic cmp,
  output logic [23:0] lo,
  output logic [23:0] hi,
  output logic none
);
  logic [23:0] sz;
  logic [23:0] ulo;
  logic [23:0] uhi;
  logic unone;
  logic uall;
  always_comb begin
    sz = 24'h000000;
    ulo = 24'h000000;
    uhi = fsp_pkg::ARRAY_TOP;
    unone = 1'b0;
    uall = 1'b0;
    // Uncomplemented map first; the complement inverts it
    if (prot[2:0] == 3'h0) begin
      unone = 1'b1;
    end else if (prot[2:1] == 2'h3 || (!prot[4] && prot[2:0] == 3'h5)) begin
      uall = 1'b1;
    end else if (!prot[4]) begin
      sz = fsp_pkg::BLK64 << (prot[2:0] - 3'h1);
      if (prot[3]) uhi = sz - 24'h000001;
      else ulo = fsp_pkg::ARRAY_TOP + 24'h000001 - sz;
    end else begin
      sz = prot[2] ? (fsp_pkg::SEC4K << 3) : (fsp_pkg::SEC4K << (prot[1:0] - 2'h1));
      if (prot[3]) uhi = sz - 24'h000001;
      else ulo = fsp_pkg::ARRAY_TOP + 24'h000001 - sz;
    end
    if (!cmp) begin
      lo = ulo;
      hi = uhi;
      none = unone;
    end else if (unone) begin
      lo = 24'h000000; // [R1]
      hi = fsp_pkg::ARRAY_TOP;
      none = 1'b0;
    end else if (uall) begin
      lo = 24'h000000; // [R1]
      hi = 24'h000000;
      none = 1'b1;
    end else if (ulo == 24'h000000) begin
      lo = uhi + 24'h000001; // [R2] [R3]
      hi = fsp_pkg::ARRAY_TOP;
      none = 1'b0;
    end else begin
      lo = 24'h000000; // [R2] [R3]
      hi = ulo - 24'h000001;
      none = 1'b0;
    end
  end
endmodule

// ### design/fsp_status.sv
`timescale 1ns/1ps
// Operation
// [R1] Complement: 000 all, 101/11x none
// [R2] Complement flips 64KB block ranges
// [R3] Complement leaves small top/bottom region
// [R4] Low status word bit layout
// [R5] High status word bit layout
// [R6] Busy high during program/erase/status write
// [R7] No write latch rejects writes
// [R8] Write latch bit mirrors latch
// [R9] Protect field changes via status write
// [R10] Hardware protect blocks protect changes
// [R11] Refuse program/erase in protected area
// [R12] Protect bits survive power cycle; the code reloads PROT_RST into them on por
// [R13] Security lock bits one-time set; the code clears them on por
// [R14] Select 01 with pin low locks
// [R15] Select 10 locks until power cycle
// [R16] Complement defaults to zero
// [R17] Quad enable repurposes protect, hold pins
// [R18] Protection refusal keeps busy low
// [R19] Compare aligned full address
module fsp_status #(
  parameter int OP_CYCLES = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic por,
  input wire logic [2:0] cmd,
  input wire logic cmd_valid,
  input wire logic [23:0] cmd_addr,
  input wire logic [7:0] wr_lo,
  input wire logic [7:0] wr_hi,
  input wire logic suspend_req,
  input wire logic resume_req,
  input wire logic wp_n_pin,
  output logic [7:0] status_word_low,
  output logic [7:0] status_word_high,
  output logic array_go,
  output logic cmd_refused,
  output logic quad_io_enable
);
  // Stored bits model the non-volatile cells; only por restores them
  logic [4:0] prot_r;
  logic cmp_r;
  logic lock_lo_r;
  logic lock_hi_r;
  logic quad_r;
  logic dummy_r;
  logic [1:0] sec_r;
  logic rsv_r;
  logic latch_r;
  logic susp_r;
  logic [15:0] cnt_r;
  logic wp_s1_r;
  logic wp_s2_r;
  fsp_pkg::fsp_state_e st_r;
  logic [23:0] p_lo;
  logic [23:0] p_hi;
  logic p_none;
  logic [23:0] a_lo;
  logic [23:0] a_hi;
  logic hit;
  logic sr_locked;
  logic is_wr;
  logic go_nxt;
  fsp_pkg::fsp_op_e op;

  fsp_decode u_dec (
    .prot(prot_r),
    .cmp(cmp_r),
    .lo(p_lo),
    .hi(p_hi),
    .none(p_none)
  );

  assign op = fsp_pkg::fsp_op_e'(cmd);

  always_comb begin
    a_lo = cmd_addr;
    a_hi = cmd_addr;
    unique case (op)
      fsp_pkg::FSP_OP_SECT: begin
        a_lo = {cmd_addr[23:12], 12'h000}; // [R19]
        a_hi = {cmd_addr[23:12], 12'hfff};
      end
      fsp_pkg::FSP_OP_B32: begin
        a_lo = {cmd_addr[23:15], 15'h0000}; // [R19]
        a_hi = {cmd_addr[23:15], 15'h7fff};
      end
      fsp_pkg::FSP_OP_B64: begin
        a_lo = {cmd_addr[23:16], 16'h0000}; // [R19]
        a_hi = {cmd_addr[23:16], 16'hffff};
      end
      default: begin
        a_lo = {cmd_addr[23:8], 8'h00};
        a_hi = {cmd_addr[23:8], 8'hff};
      end
    endcase
  end

  // Overlap test: any byte of the unit inside the range refuses it
  assign hit = !p_none && (a_lo <= p_hi) && (a_hi >= p_lo); // [R11]
  assign sr_locked = lock_hi_r || (lock_lo_r && !wp_s2_r); // [R14] [R15]
  assign is_wr = op >= fsp_pkg::FSP_OP_PAGE;
  assign go_nxt = cmd_valid && st_r == fsp_pkg::FSP_IDLE && is_wr && latch_r && !hit;

  // Pin is asynchronous; quad mode makes it data, so protect is off then
  always_ff @(posedge mclk) begin
    wp_s1_r <= wp_n_pin | quad_r; // [R17]
    wp_s2_r <= wp_s1_r;
  end

  always_ff @(posedge mclk) begin
    if (por) begin
      prot_r <= fsp_pkg::PROT_RST; // [R12]
      cmp_r <= fsp_pkg::CMP_RST; // [R16]
      {lock_hi_r, lock_lo_r} <= fsp_pkg::LOCK_RST;
      quad_r <= 1'b0;
      dummy_r <= 1'b0;
      sec_r <= 2'h0;
      rsv_r <= 1'b0;
    end else if (lock_hi_r && !lock_lo_r && rst) begin
      lock_hi_r <= lock_hi_r; // [R15]
    end else if (cmd_valid && op == fsp_pkg::FSP_OP_STATUS_WRITE_CMD && st_r == fsp_pkg::FSP_IDLE
                 && latch_r && !sr_locked) begin // [R7] [R9] [R10]
      prot_r <= wr_lo[6:2];
      lock_lo_r <= wr_lo[fsp_pkg::SL_LOCK_LO];
      lock_hi_r <= wr_hi[fsp_pkg::SH_LOCK_HI];
      quad_r <= wr_hi[fsp_pkg::SH_QUAD];
      dummy_r <= wr_hi[fsp_pkg::SH_DUMMY];
      cmp_r <= wr_hi[fsp_pkg::SH_CMP];
      rsv_r <= wr_hi[5];
      sec_r <= sec_r | wr_hi[fsp_pkg::SH_SEC_HI:fsp_pkg::SH_SEC_LO]; // [R13]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || por) begin
      latch_r <= 1'b0;
    end else if (cmd_valid && st_r == fsp_pkg::FSP_IDLE) begin
      if (op == fsp_pkg::FSP_OP_WREN) latch_r <= 1'b1;
      else if (op == fsp_pkg::FSP_OP_WRDI) latch_r <= 1'b0;
      else if ((op == fsp_pkg::FSP_OP_STATUS_WRITE_CMD && !sr_locked) || go_nxt) latch_r <= 1'b0;
    end
  end

  // Write cycle timer; the array itself lives outside
  always_ff @(posedge mclk) begin
    if (rst || por) begin
      st_r <= fsp_pkg::FSP_IDLE;
      cnt_r <= 16'h0000;
    end else if (st_r == fsp_pkg::FSP_IDLE) begin
      if (go_nxt || (cmd_valid && op == fsp_pkg::FSP_OP_STATUS_WRITE_CMD && latch_r && !sr_locked)) begin
        st_r <= fsp_pkg::FSP_BUSY; // [R6]
        cnt_r <= 16'(OP_CYCLES - 1);
      end
    end else if (!susp_r) begin
      if (cnt_r == 16'h0000) st_r <= fsp_pkg::FSP_IDLE; // [R6]
      else cnt_r <= cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || por) susp_r <= 1'b0;
    else if (resume_req) susp_r <= 1'b0;
    else if (suspend_req && st_r == fsp_pkg::FSP_BUSY) susp_r <= 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (rst || por) begin
      array_go <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      array_go <= go_nxt;
      cmd_refused <= cmd_valid && st_r == fsp_pkg::FSP_IDLE && is_wr && (!latch_r || hit); // [R18]
    end
  end

  always_ff @(posedge mclk) begin
    if (por) begin
      status_word_low <= 8'h00;
      status_word_high <= 8'h00;
      quad_io_enable <= 1'b0;
    end else begin
      status_word_low <= {lock_lo_r, prot_r, latch_r, st_r == fsp_pkg::FSP_BUSY}; // [R4] [R8]
      status_word_high <= {susp_r, cmp_r, rsv_r, dummy_r, sec_r, quad_r, lock_hi_r}; // [R5]
      quad_io_enable <= quad_r; // [R17]
    end
  end
endmodule

// ### tb/fsp_checker.sv
`timescale 1ns/1ps
module fsp_checker #(
  parameter int OP_CYCLES = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic por,
  input wire logic [2:0] cmd,
  input wire logic cmd_valid,
  input wire logic [7:0] status_word_low,
  input wire logic [7:0] status_word_high,
  input wire logic array_go,
  input wire logic cmd_refused,
  input wire logic quad_io_enable
);
  logic por_q;
  wire [7:0] sl = status_word_low;
  // Status lags one cycle, so stored-bit checks skip the cycle after power-up
  always_ff @(posedge mclk) por_q <= por;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || por);
  property p_nolatch;
    cmd_valid && cmd >= 3'h4 && sl[1:0] == 2'b00 && !$past(cmd_valid) |=> cmd_refused && !array_go;
  endproperty
  a_nolatch: assert property (p_nolatch) else $error("program without latch");
  property p_go;
    array_go |=> sl[0] && !sl[1];
  endproperty
  a_go: assert property (p_go) else $error("busy or latch wrong after start");
  // A suspend stretches the busy time, so it ends this count
  property p_len;
    disable iff (rst || por || status_word_high[7]) array_go |-> ##OP_CYCLES sl[0] ##1 !sl[0];
  endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_excl;
    !(array_go && cmd_refused);
  endproperty
  a_excl: assert property (p_excl) else $error("start and refuse together");
  property p_refbusy;
    cmd_refused |=> !sl[0];
  endproperty
  a_refbusy: assert property (p_refbusy) else $error("refusal set busy");
  property p_ignore;
    cmd_valid && $rose(sl[0]) |=> !array_go && !cmd_refused;
  endproperty
  a_ignore: assert property (p_ignore) else $error("command taken while busy");
  property p_prot;
    disable iff (rst || por || por_q) sl[6:2] != $past(sl[6:2]) |-> $past(cmd_valid, 2) && $past(cmd, 2) == 3'h3;
  endproperty
  a_prot: assert property (p_prot) else $error("protect field changed alone");
  property p_otp;
    disable iff (rst || por || por_q) ($past(status_word_high[3:2]) & ~status_word_high[3:2]) == 2'b00;
  endproperty
  a_otp: assert property (p_otp) else $error("security lock bit cleared");
  property p_por;
    $fell(por) |-> sl == 8'h00 && status_word_high == 8'h00;
  endproperty
  a_por: assert property (p_por) else $error("status not cleared by power-up");
  c_go: cover property (array_go);
  c_ref: cover property (cmd_refused);
  c_quad: cover property (quad_io_enable);
endmodule
bind fsp_status fsp_checker #(.OP_CYCLES(OP_CYCLES)) fsp_checker_i (.mclk, .rst, .por, .cmd,
  .cmd_valid, .status_word_low, .status_word_high, .array_go, .cmd_refused, .quad_io_enable);

// ### tb/fsp_host.sv
`timescale 1ns/1ps
module fsp_host (
  input wire logic mclk,
  output logic [2:0] cmd,
  output logic cmd_valid,
  output logic [23:0] cmd_addr,
  output logic [7:0] wr_lo,
  output logic [7:0] wr_hi
);
  initial {cmd, cmd_addr, wr_lo, wr_hi, cmd_valid} = '0;
  // Released lines flip so a stale value is never mistaken for a request
  task automatic send(input logic [2:0] c, input logic [23:0] a, input logic [7:0] l, h);
    @(posedge mclk);
    #1 {cmd, cmd_addr, wr_lo, wr_hi, cmd_valid} = {c, a, l, h, 1'b1};
    @(posedge mclk);
    #1 {cmd, cmd_addr, wr_lo, wr_hi, cmd_valid} = {~c, ~a, ~l, ~h, 1'b0};
  endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; $display("FAIL %0t mismatch", $time); end end
module tb;
  logic mclk, rst, por, cmd_valid, wp_n_pin, array_go, cmd_refused, quad_io_enable;
  logic [2:0] cmd;
  logic [23:0] cmd_addr;
  logic [7:0] wr_lo, wr_hi, sl, sh;
  logic susp_req, res_req;
  int miscompares = 0;
  int n_checks = 0;
  // Protect field, op, target, refused
  logic [39:0] tbl [12] = '{40'h00_5_000000_1, 40'h05_5_000000_0, 40'h06_5_0ff000_0,
    40'h09_5_00f000_0, 40'h09_7_00ffff_0, 40'h0c_5_080000_1, 40'h01_5_0ef000_1,
    40'h11_5_0ff000_0, 40'h11_5_0fe000_1, 40'h1a_5_001000_0, 40'h1a_4_002000_1,
    40'h14_6_0f8123_0};
  fsp_status #(.OP_CYCLES(4)) fsp_status_i (.mclk, .rst, .por, .cmd, .cmd_valid, .cmd_addr,
    .wr_lo, .wr_hi, .suspend_req(susp_req), .resume_req(res_req), .wp_n_pin, .status_word_low(sl),
    .status_word_high(sh), .array_go, .cmd_refused, .quad_io_enable);
  fsp_host fsp_host_i (.mclk, .cmd, .cmd_valid, .cmd_addr, .wr_lo, .wr_hi);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task idle;
    int i;
    i = 0;
    repeat (2) @(posedge mclk);
    #1;
    while (sl[0] !== 1'b0 && i < 40) begin
      @(posedge mclk);
      #1 i++;
    end
    if (i == 40) begin
      miscompares++;
      results;
    end
  endtask
  task wr(input logic [7:0] l, h);
    fsp_host_i.send(3'h1, 24'h0, 8'h00, 8'h00);
    fsp_host_i.send(3'h3, 24'h0, l, h);
    idle;
  endtask
  task t_latch;
    fsp_host_i.send(3'h4, 24'h0, 8'h00, 8'h00);
    `CHK(cmd_refused, 1'b1)
    fsp_host_i.send(3'h1, 24'h0, 8'h00, 8'h00);
    @(posedge mclk);
    #1 `CHK(sl[1], 1'b1)
    fsp_host_i.send(3'h2, 24'h0, 8'h00, 8'h00);
    @(posedge mclk);
    #1 `CHK(sl[1], 1'b0)
  endtask
  task t_map;
    for (int k = 0; k < 12; k++) begin
      wr({1'b0, tbl[k][36:32], 2'b00}, 8'h40);
      `CHK(sl[6:2], tbl[k][36:32])
      `CHK(sh, 8'h40)
      fsp_host_i.send(3'h1, 24'h0, 8'h00, 8'h00);
      fsp_host_i.send(tbl[k][30:28], tbl[k][27:4], 8'h00, 8'h00);
      `CHK(cmd_refused, tbl[k][0])
      `CHK(array_go, ~tbl[k][0])
      @(posedge mclk);
      #1 `CHK(sl[0], ~tbl[k][0])
      idle;
    end
  endtask
  task t_lock;
    wr(8'h80, 8'h00);
    wp_n_pin = 1'b0;
    repeat (3) @(posedge mclk);
    #1 wr(8'h84, 8'h00);
    `CHK(sl[7:2], 6'h20)
    wp_n_pin = 1'b1;
    repeat (3) @(posedge mclk);
    #1 wr(8'h04, 8'h00);
    `CHK(sl[7:2], 6'h01)
  endtask
  task t_susp;
    fsp_host_i.send(3'h1, 24'h0, 8'h00, 8'h00);
    fsp_host_i.send(3'h4, 24'h000100, 8'h00, 8'h00);
    `CHK(array_go, 1'b1)
    susp_req = 1'b1;
    @(posedge mclk);
    #1 susp_req = 1'b0;
    repeat (8) @(posedge mclk);
    #1 `CHK(sh[7], 1'b1)
    `CHK(sl[0], 1'b1)
    res_req = 1'b1;
    @(posedge mclk);
    #1 res_req = 1'b0;
    idle;
    `CHK(sh[7], 1'b0)
  endtask
  task t_otp;
    wr(8'h00, 8'h0e);
    `CHK(sh, 8'h0e)
    `CHK(quad_io_enable, 1'b1)
    wr(8'h00, 8'h0d);
    wr(8'h08, 8'h00);
    `CHK(sh, 8'h0d)
    `CHK(sl[7:2], 6'h00)
    por = 1'b1;
    @(posedge mclk);
    #1 por = 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK(sh[0], 1'b0)
  endtask
  initial begin
    rst = 1'b1;
    por = 1'b1;
    wp_n_pin = 1'b1;
    {susp_req, res_req} = 2'b00;
    repeat (5) @(posedge mclk);
    #1 {rst, por} = 2'b00;
    repeat (2) @(posedge mclk);
    #1 `CHK(sh, 8'h00)
    t_latch;
    t_map;
    t_lock;
    t_otp;
    t_susp;
    results;
  end
endmodule
